// ==== pct_counter.sv ====
`timescale 1ns/1ps
module pct_counter (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register access
  input pct_pkg::pct_sfr_req_type sfr_in,
  output logic [7:0] rd_data_out,
  // increment sources
  input wire logic timer0_ovf_in,
  input wire logic ext_count_in,
  input wire logic ext_osc_in,
  // processor state
  input wire logic idle_in,
  input wire logic global_irq_enable_in,
  input wire logic array_irq_enable_in,
  // status
  output logic irq_out,
  output logic wdt_enable_out,
  output logic overflow_flag_out
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [pct_pkg::PRE_W-1:0] prescale;
    logic [pct_pkg::OSC_W-1:0] osc_div;
    logic [15:0] count;
    logic [7:0] snapshot;
    logic idle_ctrl;
    logic wdt_en;
    logic flag;
    pct_pkg::pct_timebase_type sel;
    logic irq_en;
    logic [7:0] rd_data;
    logic irq;
  } pct_state_type;

  pct_state_type state_reg;
  pct_state_type state_next;

  pct_pkg::pct_edge_type ext_edge;
  pct_pkg::pct_edge_type osc_edge;

  logic tick;
  logic pre_wrap;
  logic osc_wrap;
  logic [pct_pkg::PRE_W-1:0] pre_last;

  // ==========================================================
  // functions
  function automatic logic [7:0] mode_byte(input pct_state_type s);
    logic [7:0] m;
    m = pct_pkg::BYTE_ZERO;
    m[pct_pkg::MODE_IDLE_BIT] = s.idle_ctrl;
    m[pct_pkg::MODE_WDT_BIT] = s.wdt_en;
    m[pct_pkg::MODE_FLAG_BIT] = s.flag;
    m[pct_pkg::MODE_SEL_MSB:pct_pkg::MODE_SEL_LSB] = s.sel;
    m[pct_pkg::MODE_IRQ_EN_BIT] = s.irq_en;
    return m;
  endfunction

  function automatic logic hit(input pct_pkg::pct_sfr_req_type r, input logic [7:0] a);
    return r.addr == a;
  endfunction

  // ==========================================================
  // pin synchronisers
  pct_pin_sync u_ext_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(ext_count_in),
    .edge_out(ext_edge)
  );

  // the oscillator is sampled, so it must stay below half the system clock
  pct_pin_sync u_osc_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(ext_osc_in),
    .edge_out(osc_edge)
  );

  // ==========================================================
  // timebase
  always_comb begin
    pre_last = pct_pkg::PRE_SLOW_LAST;
    if (state_reg.sel == pct_pkg::TB_CLK_DIV4) begin
      pre_last = pct_pkg::PRE_FAST_LAST;
    end
  end

  // compare with >= so a select change never strands the prescaler
  assign pre_wrap = state_reg.prescale >= pre_last;
  assign osc_wrap = osc_edge.rise && (state_reg.osc_div == pct_pkg::OSC_LAST); // [R08]

  always_comb begin
    unique case (state_reg.sel) // [R04]
      pct_pkg::TB_CLK_DIV12: tick = pre_wrap; // [R05]
      pct_pkg::TB_CLK_DIV4: tick = pre_wrap; // [R05]
      pct_pkg::TB_TIMER0: tick = timer0_ovf_in; // [R06]
      pct_pkg::TB_EXT_EDGE: tick = ext_edge.fall; // [R07]
      pct_pkg::TB_CLK: tick = 1'b1; // [R05]
      pct_pkg::TB_OSC_DIV8: tick = osc_wrap; // [R08]
      pct_pkg::TB_RSVD_6: tick = 1'b0; // [R09]
      pct_pkg::TB_RSVD_7: tick = 1'b0; // [R09]
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    state_next = state_reg;

    if (pre_wrap) begin
      state_next.prescale = '0;
    end else begin
      state_next.prescale = state_reg.prescale + 1'b1;
    end
    if (osc_edge.rise) begin
      state_next.osc_div = state_reg.osc_div + 1'b1; // [R08]
    end

    // idle pause only when the idle control bit asks for it
    if (tick && !(idle_in && state_reg.idle_ctrl)) begin // [R13] [R14]
      state_next.count = state_reg.count + 1'b1; // [R01]
    end

    // software writes; counter and mode locked while the watchdog runs, except the watchdog and flag bits
    if (sfr_in.wr && !state_reg.wdt_en) begin // [R16]
      if (hit(sfr_in, pct_pkg::ADDR_COUNT_LOW)) begin
        state_next.count[7:0] = sfr_in.data; // [R01]
      end
      if (hit(sfr_in, pct_pkg::ADDR_COUNT_HIGH)) begin
        state_next.count[15:8] = sfr_in.data; // [R01]
      end
    end
    if (sfr_in.wr && hit(sfr_in, pct_pkg::ADDR_MODE)) begin
      if (!state_reg.wdt_en) begin // [R16]
        state_next.idle_ctrl = sfr_in.data[pct_pkg::MODE_IDLE_BIT];
        state_next.sel = pct_pkg::pct_timebase_type'(
          sfr_in.data[pct_pkg::MODE_SEL_MSB:pct_pkg::MODE_SEL_LSB]);
        state_next.irq_en = sfr_in.data[pct_pkg::MODE_IRQ_EN_BIT];
      end
      // the watchdog enable itself stays writable so software can stop it
      state_next.wdt_en = sfr_in.data[pct_pkg::MODE_WDT_BIT];
      state_next.flag = sfr_in.data[pct_pkg::MODE_FLAG_BIT]; // [R12]
    end

    // hardware set beats a same-cycle software clear
    if (tick && !(idle_in && state_reg.idle_ctrl)
        && state_reg.count == pct_pkg::COUNT_MAX) begin
      state_next.flag = 1'b1; // [R10]
    end

    // reads: registered data, never touching the count
    state_next.rd_data = pct_pkg::BYTE_ZERO; // [R03]
    if (sfr_in.rd) begin
      if (hit(sfr_in, pct_pkg::ADDR_COUNT_LOW)) begin
        state_next.rd_data = state_reg.count[7:0];
        state_next.snapshot = state_reg.count[15:8]; // [R02]
      end else if (hit(sfr_in, pct_pkg::ADDR_COUNT_HIGH)) begin
        state_next.rd_data = state_reg.snapshot; // [R02]
      end else if (hit(sfr_in, pct_pkg::ADDR_MODE)) begin
        state_next.rd_data = mode_byte(state_reg);
      end
    end

    state_next.irq = state_next.flag && state_next.irq_en // [R11]
      && global_irq_enable_in && array_irq_enable_in; // [R17]
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
      state_reg.count <= pct_pkg::COUNT_RESET;
      state_reg.wdt_en <= pct_pkg::WDT_RESET; // [R15]
      state_reg.sel <= pct_pkg::TB_CLK_DIV12;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data_out = state_reg.rd_data;
  assign irq_out = state_reg.irq;
  assign wdt_enable_out = state_reg.wdt_en;
  assign overflow_flag_out = state_reg.flag;

endmodule

// ==== pct_pkg.sv ====
// How it works
// [R01] 16-bit up-counter, exposed as two bytes
// [R02] low byte read latches high byte snapshot
// [R03] reads never disturb counting
// [R04] three-bit field picks one of six sources
// [R05] codes 000/001/100: clk/12, clk/4, clk
// [R06] code 010: count timer 0 overflows
// [R07] code 011: count external input falling edges
// [R08] code 101: external oscillator /8, synchronized
// [R09] codes 110/111 reserved: counter holds
// [R10] 0xFFFF to 0x0000 wrap sets overflow flag
// [R11] overflow requests interrupt only when enabled
// [R12] flag cleared only by software write
// [R13] idle control zero: counting continues in idle
// [R14] idle control one: counting pauses in idle
// [R15] reset leaves watchdog function enabled
// [R16] watchdog enabled blocks configuration writes
// [R17] request needs global and array enables
package pct_pkg;

  // ==========================================================
  // register addresses
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hE9;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hF9;
  localparam logic [7:0] ADDR_MODE = 8'hD9;

  // ==========================================================
  // mode register layout
  localparam int MODE_IDLE_BIT = 7;
  localparam int MODE_WDT_BIT = 6;
  localparam int MODE_FLAG_BIT = 4;
  localparam int MODE_SEL_LSB = 1;
  localparam int MODE_SEL_MSB = 3;
  localparam int MODE_IRQ_EN_BIT = 0;
  localparam logic [7:0] MODE_WRITE_MASK = 8'hDF;

  // ==========================================================
  // reset values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic WDT_RESET = 1'b1;

  // ==========================================================
  // timebase dividers
  localparam int DIV_SLOW = 12;
  localparam int DIV_FAST = 4;
  localparam int OSC_DIV = 8;
  localparam int PRE_W = $clog2(DIV_SLOW);
  localparam int OSC_W = $clog2(OSC_DIV);
  localparam logic [PRE_W-1:0] PRE_SLOW_LAST = PRE_W'(DIV_SLOW - 1);
  localparam logic [PRE_W-1:0] PRE_FAST_LAST = PRE_W'(DIV_FAST - 1);
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_DIV - 1);

  typedef enum logic [2:0] {
    TB_CLK_DIV12 = 3'b000,
    TB_CLK_DIV4 = 3'b001,
    TB_TIMER0 = 3'b010,
    TB_EXT_EDGE = 3'b011,
    TB_CLK = 3'b100,
    TB_OSC_DIV8 = 3'b101,
    TB_RSVD_6 = 3'b110,
    TB_RSVD_7 = 3'b111
  } pct_timebase_type;

  // ==========================================================
  // special function register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } pct_sfr_req_type;

  typedef struct packed {
    logic fall;
    logic rise;
  } pct_edge_type;

endpackage

// ==== pct_pin_sync.sv ====
`timescale 1ns/1ps
module pct_pin_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // asynchronous level
  input wire logic pin_in,
  // edges in the clock domain
  output pct_pkg::pct_edge_type edge_out
);

  typedef struct packed {
    logic stage1;
    logic stage2;
    logic prev;
  } pct_sync_state_type;

  pct_sync_state_type state_reg;
  pct_sync_state_type state_next;

  always_comb begin
    state_next = state_reg;
    state_next.stage1 = pin_in;
    state_next.stage2 = state_reg.stage1;
    state_next.prev = state_reg.stage2;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // only the second stage and its delayed copy feed the edge logic
  assign edge_out.fall = state_reg.prev & ~state_reg.stage2;
  assign edge_out.rise = ~state_reg.prev & state_reg.stage2;

endmodule

// ==== pct_counter_props.sv ====
`timescale 1ns/1ps
module pct_counter_props (
  // watched ports
  input wire logic clk_in,
  input wire logic rst_n_in,
  input pct_pkg::pct_sfr_req_type sfr_in,
  input wire logic [7:0] rd_data_out,
  input wire logic global_irq_enable_in,
  input wire logic array_irq_enable_in,
  input wire logic irq_out,
  input wire logic wdt_enable_out,
  input wire logic overflow_flag_out
);
  // ========================================
  // checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire mode_wr = sfr_in.wr && sfr_in.addr == pct_pkg::ADDR_MODE;
  a_irq_enables: assert property (irq_out |-> $past(global_irq_enable_in && array_irq_enable_in))
    else $error("irq without enables");
  a_irq_flag: assert property (irq_out |-> overflow_flag_out)
    else $error("irq without flag");
  a_flag_sw_clear: assert property ($fell(overflow_flag_out) |-> $past(mode_wr && !sfr_in.data[4]))
    else $error("flag cleared without write");
  a_wdt_reset: assert property ($rose(rst_n_in) |-> wdt_enable_out)
    else $error("watchdog off after reset");
  a_wdt_write: assert property (mode_wr |=> wdt_enable_out == $past(sfr_in.data[6]))
    else $error("watchdog bit not written");
  a_wdt_hold: assert property (!mode_wr |=> $stable(wdt_enable_out))
    else $error("watchdog bit moved");
  a_read_pulse: assert property (!sfr_in.rd |=> rd_data_out == 8'h00)
    else $error("read data without read");
  a_unmapped_zero: assert property (sfr_in.rd && !(sfr_in.addr inside {8'hE9, 8'hF9, 8'hD9})
    |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");
  a_mode_read: assert property (sfr_in.rd && !sfr_in.wr && sfr_in.addr == pct_pkg::ADDR_MODE
    |=> rd_data_out[6:4] == {$past(wdt_enable_out), 1'b0, $past(overflow_flag_out)})
    else $error("mode read mismatch");
endmodule

// ==== test_pct_counter_timebase.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  tests_run++; \
  if ((got) !== (ex)) begin \
    n_mismatch++; \
    $display("mismatch %s exp %0h got %0h", nm, ex, got); \
  end
module test_pct_counter_timebase;
  // ========================================
  // stimulus and wiring
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  pct_pkg::pct_sfr_req_type sfr = '0;
  logic t0 = 1'b0;
  logic ext = 1'b1;
  logic osc = 1'b0;
  logic idle = 1'b0;
  logic gie = 1'b0;
  logic aie = 1'b0;
  logic [7:0] rd_q;
  logic [7:0] rd;
  logic irq, wdt, flag;
  int cyc = 0;
  int n_mismatch = 0;
  int tests_run = 0;
  localparam int GAP = 96;
  always #25 clk_in = ~clk_in;
  pct_counter DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .sfr_in(sfr), .rd_data_out(rd_q),
    .timer0_ovf_in(t0), .ext_count_in(ext), .ext_osc_in(osc), .idle_in(idle),
    .global_irq_enable_in(gie), .array_irq_enable_in(aie), .irq_out(irq),
    .wdt_enable_out(wdt), .overflow_flag_out(flag));
  // sources run free; GAP holds whole periods of each, so counts do not hang on phase
  always @(posedge clk_in) begin
    #1;
    cyc++;
    t0 = (cyc % 16 == 0);
    ext = (cyc % 16 < 8);
    osc = (cyc % 6 < 3);
    if (cyc == 5000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    sfr = '{w, !w, a, d};
    @(posedge clk_in);
    #1;
    // read data stands for one cycle only, so take it now
    rd = rd_q;
    sfr = '0;
    // one idle edge so back-to-back calls never drive sfr twice in a step
    @(posedge clk_in);
    #1;
  endtask
  task automatic rate(input logic [7:0] mode, input logic idl, input logic [7:0] ex);
    logic [7:0] first;
    idle = idl;
    acc(1'b1, pct_pkg::ADDR_MODE, mode);
    acc(1'b0, pct_pkg::ADDR_COUNT_LOW, 8'h00);
    first = rd;
    // each access spans two edges, so the read edges sit exactly GAP apart
    repeat (GAP - 2) @(posedge clk_in);
    #1;
    // the counted window is over; the final read edge no longer depends on idle
    idle = 1'b0;
    acc(1'b0, pct_pkg::ADDR_COUNT_LOW, 8'h00);
    `CHK("count step", ex, rd - first)
    $display("rate test mode %0h done", mode);
  endtask
  task automatic t_lock;
    acc(1'b0, pct_pkg::ADDR_MODE, 8'h00);
    `CHK("reset mode", 8'h40, rd)
    `CHK("watchdog on", 1'b1, wdt)
    acc(1'b1, pct_pkg::ADDR_MODE, 8'hCB);
    acc(1'b1, pct_pkg::ADDR_COUNT_LOW, 8'hF0);
    acc(1'b0, pct_pkg::ADDR_COUNT_LOW, 8'h00);
    `CHK("locked count", 1'b1, rd < 8'h10)
    acc(1'b0, pct_pkg::ADDR_MODE, 8'h00);
    `CHK("locked mode", 8'h40, rd)
    acc(1'b1, pct_pkg::ADDR_MODE, 8'h00);
    `CHK("watchdog off", 1'b0, wdt)
    acc(1'b0, 8'h55, 8'h00);
    `CHK("unmapped", 8'h00, rd)
    $display("lock test done");
  endtask
  task automatic t_snap;
    acc(1'b1, pct_pkg::ADDR_MODE, 8'h08);
    // low first: a carry can no longer ripple into the high byte just written
    acc(1'b1, pct_pkg::ADDR_COUNT_LOW, 8'h00);
    acc(1'b1, pct_pkg::ADDR_COUNT_HIGH, 8'h12);
    acc(1'b0, pct_pkg::ADDR_COUNT_LOW, 8'h00);
    // counting every clock: two edges to the high write, one more to the read
    `CHK("low byte", 8'h03, rd)
    repeat (300) @(posedge clk_in);
    #1;
    acc(1'b0, pct_pkg::ADDR_COUNT_HIGH, 8'h00);
    `CHK("snapshot", 8'h12, rd)
    $display("snapshot test done");
  endtask
  task automatic t_ovf;
    gie = 1'b1;
    aie = 1'b1;
    acc(1'b1, pct_pkg::ADDR_MODE, 8'h09);
    acc(1'b1, pct_pkg::ADDR_COUNT_LOW, 8'hF0);
    acc(1'b1, pct_pkg::ADDR_COUNT_HIGH, 8'hFF);
    repeat (8) @(posedge clk_in);
    #1;
    `CHK("flag early", 1'b0, flag)
    repeat (12) @(posedge clk_in);
    #1;
    `CHK("flag", 1'b1, flag)
    `CHK("irq", 1'b1, irq)
    gie = 1'b0;
    @(posedge clk_in);
    #1;
    `CHK("irq masked", 1'b0, irq)
    gie = 1'b1;
    acc(1'b1, pct_pkg::ADDR_MODE, 8'h18);
    `CHK("irq disabled", 1'b0, irq)
    `CHK("flag kept", 1'b1, flag)
    acc(1'b1, pct_pkg::ADDR_MODE, 8'h08);
    `CHK("flag cleared", 1'b0, flag)
    $display("overflow test done");
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    t_lock();
    rate(8'h00, 1'b0, 8'h08);
    rate(8'h02, 1'b0, 8'h18);
    rate(8'h08, 1'b0, 8'h60);
    rate(8'h04, 1'b0, 8'h06);
    rate(8'h06, 1'b0, 8'h06);
    rate(8'h0A, 1'b0, 8'h02);
    rate(8'h0C, 1'b0, 8'h00);
    rate(8'h0E, 1'b0, 8'h00);
    rate(8'h08, 1'b1, 8'h60);
    rate(8'h88, 1'b1, 8'h00);
    t_snap();
    t_ovf();
    complete_run();
  end
endmodule
bind pct_counter pct_counter_props u_props (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .sfr_in(sfr_in), .rd_data_out(rd_data_out), .global_irq_enable_in(global_irq_enable_in),
  .array_irq_enable_in(array_irq_enable_in), .irq_out(irq_out),
  .wdt_enable_out(wdt_enable_out), .overflow_flag_out(overflow_flag_out));
